//--- common/sopc_pkg.sv
package sopc_pkg;

   // =====================================================================
   // serial word layout
   localparam int unsigned SHIFT_W    = 19;
   localparam int unsigned CNT_BIT    = 0;
   localparam logic        CNT_REF    = 1'b1;
   localparam int unsigned R_LSB      = 1;
   localparam int unsigned R_W        = 14;
   localparam int unsigned SW_BIT     = 15;
   localparam int unsigned POL_BIT    = 16;
   localparam int unsigned LDS_BIT    = 17;
   localparam int unsigned CS_BIT     = 18;
   localparam int unsigned A_LSB      = 1;
   localparam int unsigned A_W        = 7;
   localparam int unsigned N_LSB      = 8;
   localparam int unsigned N_W        = 11;
   localparam logic [SHIFT_W-1:0] WORD_RST = 19'h00000;

   // =====================================================================
   // register map
   localparam int unsigned ADDR_W     = 8;
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_REFDIV = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PRGDIV = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_LOADS  = 8'h10;

   localparam int unsigned CTRL_LIM_EN_BIT = 0;
   localparam int unsigned CTRL_LIM_LSB    = 8;
   localparam int unsigned CTRL_LIM_W      = 8;

   localparam int unsigned ST_PSAVE   = 0;
   localparam int unsigned ST_LOCK    = 1;
   localparam int unsigned ST_DRIVE   = 2;
   localparam int unsigned ST_LEVEL   = 3;
   localparam int unsigned ST_UP      = 4;
   localparam int unsigned ST_DN      = 5;
   localparam int unsigned ST_RESTART = 6;
   localparam int unsigned ST_TRI     = 7;

   localparam int unsigned LOADS_W    = 16;

   // =====================================================================
   // timing
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned ERR_LIMIT_NS  = 20;
   localparam int unsigned RESTART_NS    = 10000;
   localparam int unsigned LOCK_NS       = 500;
   localparam int unsigned ERR_LIMIT_CYC = (ERR_LIMIT_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned RESTART_CYC   = (RESTART_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned LOCK_CYC      = (LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RESTART_W     = 12;
   localparam int unsigned LOCK_W        = 8;

   localparam logic [CTRL_LIM_W-1:0] LIM_RST = CTRL_LIM_W'(ERR_LIMIT_CYC);

endpackage

//--- common/sopc_ser_if.sv
`timescale 1ns/1ps
interface sopc_ser_if;
   logic [sopc_pkg::SHIFT_W-1:0] shift_word;
   modport link (output shift_word);
   modport core (input  shift_word);
endinterface

//--- src/sopc_shift.sv
`timescale 1ns/1ps
module sopc_shift (
   input  wire logic  sclk_i,
   input  wire logic  nrst_i,
   input  wire logic  sdata_i,
   input  wire logic  load_strobe_i,
   sopc_ser_if.link   ser
);

   logic [sopc_pkg::SHIFT_W-1:0] word_reg;

   // =====================================================================
   // serial shifter, link clock domain
   // shift on rise
   always_ff @(posedge sclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         word_reg <= sopc_pkg::WORD_RST;
      end else if (!load_strobe_i) begin
         word_reg <= {sdata_i, word_reg[sopc_pkg::SHIFT_W-1:1]};
      end
   end

   assign ser.shift_word = word_reg;

endmodule // sopc_shift

//--- src/sopc_top.sv
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - pump output drives when tristate control high, floats when low.
// - low_power_select_n low means power saving, high means normal.
// - in power saving the pump output floats regardless of tristate control.
// - in power saving the lock indicator stays high.
// - power select high again resumes comparator operation.
// - after leaving power saving, comparator error pulses are limited.
// - each rising serial clock edge while the load strobe is low shifts one data bit in.
// - phase polarity bit reverses pump and comparator output sense.
module sopc_top (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic        sclk_i,
   input  wire logic        sdata_i,
   input  wire logic        load_strobe_i,
   input  wire logic        pump_tristate_ctrl_i,
   input  wire logic        low_power_select_n_i,
   input  wire logic        reference_frequency_i,
   input  wire logic        compare_frequency_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             pump_o,
   output logic             pump_oe_o,
   output logic             phase_ref_o,
   output logic             phase_cmp_o,
   output logic             phase_cmp_oe_o,
   output logic             lock_indicator_o,
   output logic             lock_mon_o,
   output logic             prescale_sel_o,
   output logic             pump_current_sel_o
);

   // =====================================================================
   // helpers
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction

   // =====================================================================
   // serial link
   sopc_ser_if ser ();

   sopc_shift u_shift (
      .sclk_i        (sclk_i),
      .nrst_i        (nrst_i),
      .sdata_i       (sdata_i),
      .load_strobe_i (load_strobe_i),
      .ser           (ser.link)
   );

   // =====================================================================
   // synchronisers
   logic [sopc_pkg::SHIFT_W-1:0] word_s1_reg;
   logic [sopc_pkg::SHIFT_W-1:0] word_s2_reg;
   logic [1:0]                   stb_sync_reg;
   logic [1:0]                   tri_sync_reg;
   logic [1:0]                   lp_sync_reg;
   logic [1:0]                   ref_sync_reg;
   logic [1:0]                   cmp_sync_reg;
   logic                         stb_prev_reg;
   logic                         ref_prev_reg;
   logic                         cmp_prev_reg;
   logic                         lp_prev_reg;

   // word is stable while the strobe is high, so a plain two-stage copy suffices
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         word_s1_reg <= sopc_pkg::WORD_RST;
         word_s2_reg <= sopc_pkg::WORD_RST;
      end else begin
         word_s1_reg <= ser.shift_word;
         word_s2_reg <= word_s1_reg;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stb_sync_reg <= '1;
         tri_sync_reg <= 2'h0;
         lp_sync_reg  <= 2'h0;
         ref_sync_reg <= 2'h0;
         cmp_sync_reg <= 2'h0;
      end else begin
         stb_sync_reg <= {stb_sync_reg[0], load_strobe_i};
         tri_sync_reg <= {tri_sync_reg[0], pump_tristate_ctrl_i};
         lp_sync_reg  <= {lp_sync_reg[0], low_power_select_n_i};
         ref_sync_reg <= {ref_sync_reg[0], reference_frequency_i};
         cmp_sync_reg <= {cmp_sync_reg[0], compare_frequency_i};
      end
   end

   // strobe idles high: its history resets high, else a false load follows reset
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stb_prev_reg <= 1'b1;
         ref_prev_reg <= 1'b0;
         cmp_prev_reg <= 1'b0;
         lp_prev_reg  <= 1'b0;
      end else begin
         stb_prev_reg <= stb_sync_reg[1];
         ref_prev_reg <= ref_sync_reg[1];
         cmp_prev_reg <= cmp_sync_reg[1];
         lp_prev_reg  <= lp_sync_reg[1];
      end
   end

   logic stb_rise;
   logic ref_rise;
   logic cmp_rise;
   logic psave;
   logic wake;
   logic tri_en;

   assign stb_rise = rise(stb_sync_reg[1], stb_prev_reg);
   assign ref_rise = rise(ref_sync_reg[1], ref_prev_reg);
   assign cmp_rise = rise(cmp_sync_reg[1], cmp_prev_reg);
   assign psave    = ~lp_sync_reg[1];
   assign wake     = rise(lp_sync_reg[1], lp_prev_reg);
   assign tri_en   = tri_sync_reg[1];

   // =====================================================================
   // divider registers
   logic [sopc_pkg::SHIFT_W-1:0] ref_word_reg;
   logic [sopc_pkg::SHIFT_W-1:0] prg_word_reg;
   logic [sopc_pkg::LOADS_W-1:0] loads_reg;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ref_word_reg <= sopc_pkg::WORD_RST;
         prg_word_reg <= sopc_pkg::WORD_RST;
      end else if (stb_rise) begin
         if (word_s2_reg[sopc_pkg::CNT_BIT] == sopc_pkg::CNT_REF) begin
            ref_word_reg <= word_s2_reg;
         end else begin
            prg_word_reg <= word_s2_reg;
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         loads_reg <= '0;
      end else if (stb_rise) begin
         loads_reg <= loads_reg + sopc_pkg::LOADS_W'(1);
      end
   end

   logic pol;
   logic lds;

   assign pol = ref_word_reg[sopc_pkg::POL_BIT];
   assign lds = ref_word_reg[sopc_pkg::LDS_BIT];

   // =====================================================================
   // control register
   logic                            lim_en_reg;
   logic [sopc_pkg::CTRL_LIM_W-1:0] lim_cyc_reg;
   logic                            access;
   logic                            wr_done;

   assign access  = psel_i & penable_i;
   assign wr_done = access & pready_o & pwrite_i;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lim_en_reg  <= 1'b1;
         lim_cyc_reg <= sopc_pkg::LIM_RST;
      end else if (wr_done && paddr_i == sopc_pkg::OFF_CTRL) begin
         if (pstrb_i[0]) begin
            lim_en_reg <= pwdata_i[sopc_pkg::CTRL_LIM_EN_BIT];
         end
         if (pstrb_i[1]) begin
            lim_cyc_reg <= pwdata_i[sopc_pkg::CTRL_LIM_LSB +: sopc_pkg::CTRL_LIM_W];
         end
      end
   end

   // =====================================================================
   // phase comparator
   logic                            up_reg;
   logic                            dn_reg;
   logic [sopc_pkg::RESTART_W-1:0]  restart_reg;
   logic [sopc_pkg::CTRL_LIM_W-1:0] err_reg;
   logic                            clip;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         restart_reg <= '0;
      end else if (wake) begin
         restart_reg <= sopc_pkg::RESTART_W'(sopc_pkg::RESTART_CYC);
      end else if (psave) begin
         restart_reg <= '0;
      end else if (restart_reg != '0) begin
         restart_reg <= restart_reg - sopc_pkg::RESTART_W'(1);
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         err_reg <= '0;
      end else if (!(up_reg ^ dn_reg)) begin
         err_reg <= '0;
      end else if (err_reg != '1) begin
         err_reg <= err_reg + sopc_pkg::CTRL_LIM_W'(1);
      end
   end

   assign clip = lim_en_reg & (restart_reg != '0) & (err_reg >= lim_cyc_reg);

   // comparator held idle in power saving, resumes after
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         up_reg <= 1'b0;
         dn_reg <= 1'b0;
      end else if (psave) begin
         up_reg <= 1'b0;
         dn_reg <= 1'b0;
      end else if ((up_reg | ref_rise) & (dn_reg | cmp_rise)) begin
         up_reg <= 1'b0;
         dn_reg <= 1'b0;
      end else begin
         up_reg <= up_reg | ref_rise;
         dn_reg <= dn_reg | cmp_rise;
      end
   end

   // =====================================================================
   // charge pump and comparator outputs
   logic active;

   assign active = (up_reg ^ dn_reg) & ~clip;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pump_o    <= 1'b0;
         pump_oe_o <= 1'b0;
      end else begin
         pump_o    <= up_reg ? pol : ~pol;
         pump_oe_o <= active & tri_en & ~psave;
      end
   end

   // phase_cmp only ever pulls low; otherwise it floats
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_ref_o    <= 1'b0;
         phase_cmp_o    <= 1'b0;
         phase_cmp_oe_o <= 1'b0;
      end else begin
         phase_ref_o    <= active & (pol ? dn_reg : up_reg);
         phase_cmp_o    <= 1'b0;
         phase_cmp_oe_o <= active & (pol ? up_reg : dn_reg);
      end
   end

   // =====================================================================
   // lock detect
   logic [sopc_pkg::LOCK_W-1:0] quiet_reg;
   logic                        locked;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         quiet_reg <= '0;
      end else if (up_reg | dn_reg) begin
         quiet_reg <= '0;
      end else if (quiet_reg != sopc_pkg::LOCK_W'(sopc_pkg::LOCK_CYC)) begin
         quiet_reg <= quiet_reg + sopc_pkg::LOCK_W'(1);
      end
   end

   assign locked = psave | (quiet_reg == sopc_pkg::LOCK_W'(sopc_pkg::LOCK_CYC));

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lock_indicator_o <= 1'b0;
         lock_mon_o       <= 1'b0;
      end else begin
         lock_indicator_o <= locked;
         // monitor pin: lock or divided frequency, chosen by the word
         lock_mon_o       <= lds ? (pol ? ref_sync_reg[1] : cmp_sync_reg[1]) : locked;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prescale_sel_o     <= 1'b0;
         pump_current_sel_o <= 1'b0;
      end else begin
         prescale_sel_o     <= ref_word_reg[sopc_pkg::SW_BIT];
         pump_current_sel_o <= ref_word_reg[sopc_pkg::CS_BIT];
      end
   end

   // =====================================================================
   // apb slave: one wait state, read data registered
   logic [31:0] rd_word;
   logic        mapped;

   always_comb begin
      rd_word = 32'h00000000;
      mapped  = 1'b1;
      case (paddr_i)
         sopc_pkg::OFF_CTRL: begin
            rd_word[sopc_pkg::CTRL_LIM_EN_BIT] = lim_en_reg;
            rd_word[sopc_pkg::CTRL_LIM_LSB +: sopc_pkg::CTRL_LIM_W] = lim_cyc_reg;
         end
         sopc_pkg::OFF_STATUS: begin
            rd_word[sopc_pkg::ST_PSAVE]   = psave;
            rd_word[sopc_pkg::ST_LOCK]    = locked;
            rd_word[sopc_pkg::ST_DRIVE]   = pump_oe_o;
            rd_word[sopc_pkg::ST_LEVEL]   = pump_o;
            rd_word[sopc_pkg::ST_UP]      = up_reg;
            rd_word[sopc_pkg::ST_DN]      = dn_reg;
            rd_word[sopc_pkg::ST_RESTART] = (restart_reg != '0);
            rd_word[sopc_pkg::ST_TRI]     = tri_en;
         end
         sopc_pkg::OFF_REFDIV: begin
            rd_word[sopc_pkg::SHIFT_W-1:0] = ref_word_reg;
         end
         sopc_pkg::OFF_PRGDIV: begin
            rd_word[sopc_pkg::SHIFT_W-1:0] = prg_word_reg;
         end
         sopc_pkg::OFF_LOADS: begin
            rd_word[sopc_pkg::LOADS_W-1:0] = loads_reg;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else if (access & ~pready_o) begin
         pready_o  <= 1'b1;
         pslverr_o <= ~mapped;
         prdata_o  <= pwrite_i ? 32'h00000000 : rd_word;
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end
   end

endmodule // sopc_top

//--- tb/sopc_top_monitor.sv
`timescale 1ns/1ps
module sopc_top_monitor (
   input  wire logic        clock_i,
   input  wire logic        nrst_i,
   input  wire logic        sclk_i,
   input  wire logic        sdata_i,
   input  wire logic        load_strobe_i,
   input  wire logic        pump_tristate_ctrl_i,
   input  wire logic        low_power_select_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic [31:0] prdata_o,
   input  wire logic        pready_o,
   input  wire logic        pslverr_o,
   input  wire logic        pump_oe_o,
   input  wire logic        lock_indicator_o,
   input  wire logic        prescale_sel_o,
   input  wire logic        pump_current_sel_o
);
   // slack over the limit for sync and register delay
   localparam int RUN_MAX = 7;
   logic [sopc_pkg::SHIFT_W-1:0] shadow_reg;
   logic [11:0]                  win_reg;
   logic [7:0]                   run_reg;
   logic                         lp_d_reg;
   // =================================
   // helpers
   always_ff @(posedge sclk_i or negedge nrst_i) begin
      if (!nrst_i) shadow_reg <= '0;
      else if (!load_strobe_i) shadow_reg <= {sdata_i, shadow_reg[sopc_pkg::SHIFT_W-1:1]};
   end
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) lp_d_reg <= 1'b0;
      else lp_d_reg <= low_power_select_n_i;
   end
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) win_reg <= '0;
      else if (low_power_select_n_i && !lp_d_reg) win_reg <= 12'h001;
      else if (win_reg != 12'h000 && win_reg < 12'h834) win_reg <= win_reg + 12'h001;
      else win_reg <= '0;
   end
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) run_reg <= '0;
      else if (!pump_oe_o) run_reg <= '0;
      else if (run_reg != 8'hff) run_reg <= run_reg + 8'h01;
   end
   // =================================
   // properties
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   a_tri_float: assert property ((!pump_tristate_ctrl_i)[*5] |-> !pump_oe_o)
      else $error("pump driven with tristate control low");
   a_psave_float: assert property ((!low_power_select_n_i)[*5] |-> !pump_oe_o)
      else $error("pump driven in power saving");
   a_psave_lock: assert property ((!low_power_select_n_i)[*6] |-> lock_indicator_o)
      else $error("lock low in power saving");
   a_restart_limit: assert property ((win_reg > 12'h008 && win_reg < 12'h7c6)
      |-> run_reg <= RUN_MAX)
      else $error("long pump pulse in restart window");
   a_ref_load: assert property ($rose(load_strobe_i) && shadow_reg[0] |-> ##5
      (prescale_sel_o == shadow_reg[sopc_pkg::SW_BIT]
       && pump_current_sel_o == shadow_reg[sopc_pkg::CS_BIT]))
      else $error("reference word not transferred");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   a_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("access phase not answered");
   a_err_ready: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data outside ready cycle");
   c_psave: cover property ($fell(low_power_select_n_i));
   c_slverr: cover property (pslverr_o);
   c_refload: cover property ($rose(load_strobe_i) && shadow_reg[0]);
endmodule // sopc_top_monitor

//--- tb/sopc_host_model.sv
`timescale 1ns/1ps
module sopc_host_model (
   output logic sclk_o,
   output logic sdata_o,
   output logic load_strobe_o,
   output logic pump_tristate_ctrl_o,
   output logic low_power_select_n_o
);
   // =================================
   // pins at power-up
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      load_strobe_o = 1'b1;
      pump_tristate_ctrl_o = 1'b0;
      // start in standby, bench waits over 1 us
      low_power_select_n_o = 1'b0;
   end
   // =================================
   // serial frame, lsb first, clock still outside frames
   task automatic send_word(input logic [sopc_pkg::SHIFT_W-1:0] w);
      int i;
      // odd offset keeps link edges off the system clock edges
      #1.3;
      load_strobe_o = 1'b0;
      #125;
      for (i = 0; i < sopc_pkg::SHIFT_W; i++) begin
         sdata_o = w[i];
         #62.5 sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
      end
      // released line shows no stale bit
      sdata_o = ~sdata_o;
      #62.5 load_strobe_o = 1'b1;
      #250;
   endtask
   task automatic set_pins(input logic tri_v, input logic lp_v);
      pump_tristate_ctrl_o <= tri_v;
      low_power_select_n_o <= lp_v;
   endtask
endmodule // sopc_host_model

//--- tb/test_sopc_top.sv
`timescale 1ns/1ps
module test_sopc_top;
   logic        clock_i, nrst_i, ref_f, cmp_f, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, pump, pump_oe, lock, pre_sel, cur_sel, err, pol_seen;
   logic        sclk, sdata, strobe, tri_c, lp_n, phr, pcm, pcoe, lmon;
   logic [2:0]  ph_seen;
   int          n_mismatch, compares, cycles, oe_run, oe_max;
   logic [18:0] ref1, ref2, prg;

   sopc_host_model sopc_host_model_inst (.sclk_o(sclk), .sdata_o(sdata),
      .load_strobe_o(strobe), .pump_tristate_ctrl_o(tri_c), .low_power_select_n_o(lp_n));
   sopc_top sopc_top_inst (.clock_i(clock_i), .nrst_i(nrst_i), .sclk_i(sclk),
      .sdata_i(sdata), .load_strobe_i(strobe), .pump_tristate_ctrl_i(tri_c),
      .low_power_select_n_i(lp_n), .reference_frequency_i(ref_f), .compare_frequency_i(cmp_f),
      .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .pump_o(pump), .pump_oe_o(pump_oe), .phase_ref_o(phr),
      .phase_cmp_o(pcm), .phase_cmp_oe_o(pcoe), .lock_indicator_o(lock), .lock_mon_o(lmon),
      .prescale_sel_o(pre_sel), .pump_current_sel_o(cur_sel));

   always #2.5 clock_i = ~clock_i;
   // =================================
   // pump pulse watcher and timeout
   always @(posedge clock_i) begin
      if (pump_oe === 1'b1) begin
         oe_run++;
         if (oe_run > oe_max) oe_max = oe_run;
         pol_seen = pump;
         ph_seen = {phr, pcm, pcoe};
      end else oe_run = 0;
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // =================================
   // tasks
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_pin(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clock_i);
      penable <= 1'b1;
      do begin
         @(posedge clock_i);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check_word(name, exp, rd);
   endtask
   // one lead edge, then the lagging edge clears the error
   task automatic pulse(input logic dn_first);
      @(posedge clock_i);
      oe_max = 0;
      if (dn_first) cmp_f <= 1'b1;
      else ref_f <= 1'b1;
      repeat (60) @(posedge clock_i);
      ref_f <= 1'b1;
      cmp_f <= 1'b1;
      repeat (8) @(posedge clock_i);
      ref_f <= 1'b0;
      cmp_f <= 1'b0;
      repeat (20) @(posedge clock_i);
   endtask
   function automatic logic [18:0] ref_word(input logic [13:0] r, input logic sw,
                                            input logic pol, input logic cs);
      logic [18:0] w;
      w = '0;
      w[sopc_pkg::CNT_BIT] = sopc_pkg::CNT_REF;
      w[sopc_pkg::R_LSB +: sopc_pkg::R_W] = r;
      w[sopc_pkg::SW_BIT] = sw;
      w[sopc_pkg::POL_BIT] = pol;
      w[sopc_pkg::CS_BIT] = cs;
      return w;
   endfunction
   // =================================
   // main sequence
   initial begin
      clock_i = 0; nrst_i = 0; ref_f = 0; cmp_f = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 8'h00; pwdata = 32'h0; n_mismatch = 0; compares = 0; cycles = 0;
      oe_run = 0; oe_max = 0; pol_seen = 0; ph_seen = 3'h0;
      ref1 = ref_word(14'h0005, 1'b1, 1'b1, 1'b1);
      ref2 = ref_word(14'h0005, 1'b0, 1'b0, 1'b0);
      prg = {11'h064, 7'h03, ~sopc_pkg::CNT_REF};
      repeat (3) @(posedge clock_i);
      nrst_i <= 1'b1;
      repeat (250) @(posedge clock_i);
      rd_chk("ctrl_rst", sopc_pkg::OFF_CTRL, 32'h0000_0401);
      apb(1'b0, sopc_pkg::OFF_STATUS, 32'h0);
      check_pin("psave_flag", 1'b1, rd[sopc_pkg::ST_PSAVE]);
      check_pin("lock_psave", 1'b1, lock);
      check_pin("oe_psave", 1'b0, pump_oe);
      apb(1'b0, 8'h14, 32'h0);
      check_pin("unmapped_err", 1'b1, err);
      apb(1'b1, sopc_pkg::OFF_CTRL, 32'h0000_0501);
      rd_chk("ctrl_wr", sopc_pkg::OFF_CTRL, 32'h0000_0501);
      sopc_host_model_inst.send_word(ref1);
      repeat (10) @(posedge clock_i);
      rd_chk("refdiv", sopc_pkg::OFF_REFDIV, 32'(ref1));
      check_pin("prescale", 1'b1, pre_sel);
      check_pin("cur_sel", 1'b1, cur_sel);
      sopc_host_model_inst.send_word(prg);
      repeat (10) @(posedge clock_i);
      rd_chk("prgdiv", sopc_pkg::OFF_PRGDIV, 32'(prg));
      rd_chk("loads", sopc_pkg::OFF_LOADS, 32'h0000_0002);
      sopc_host_model_inst.set_pins(1'b1, 1'b1);
      repeat (20) @(posedge clock_i);
      pulse(1'b0);
      check_pin("restart_cut", 1'b1, 1'(oe_max >= 1 && oe_max <= 7));
      repeat (2100) @(posedge clock_i);
      pulse(1'b0);
      check_pin("drive_long", 1'b1, 1'(oe_max > 40));
      check_pin("up_pol_high", 1'b1, pol_seen);
      check_word("phase_up_pol_high", 32'h0000_0001, 32'(ph_seen));
      sopc_host_model_inst.set_pins(1'b0, 1'b1);
      repeat (10) @(posedge clock_i);
      pulse(1'b0);
      check_pin("tri_float", 1'b1, 1'(oe_max == 0));
      sopc_host_model_inst.send_word(ref2);
      sopc_host_model_inst.set_pins(1'b1, 1'b1);
      repeat (10) @(posedge clock_i);
      pulse(1'b0);
      check_pin("up_pol_low", 1'b0, pol_seen);
      check_word("phase_up_pol_low", 32'h0000_0004, 32'(ph_seen));
      pulse(1'b1);
      check_pin("dn_pol_low", 1'b1, pol_seen);
      check_word("phase_dn_pol_low", 32'h0000_0001, 32'(ph_seen));
      sopc_host_model_inst.set_pins(1'b1, 1'b0);
      repeat (10) @(posedge clock_i);
      check_pin("oe_psave2", 1'b0, pump_oe);
      check_pin("lock_psave2", 1'b1, lock);
      check_pin("lock_mon_psave2", 1'b1, lmon);
      apb(1'b0, sopc_pkg::OFF_STATUS, 32'h0);
      check_pin("psave_flag2", 1'b1, rd[sopc_pkg::ST_PSAVE]);
      wrap_up();
   end
endmodule // test_sopc_top

bind sopc_top sopc_top_monitor sopc_top_monitor_inst (.clock_i(clock_i), .nrst_i(nrst_i),
   .sclk_i(sclk_i), .sdata_i(sdata_i), .load_strobe_i(load_strobe_i),
   .pump_tristate_ctrl_i(pump_tristate_ctrl_i), .low_power_select_n_i(low_power_select_n_i),
   .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .pump_oe_o(pump_oe_o), .lock_indicator_o(lock_indicator_o),
   .prescale_sel_o(prescale_sel_o), .pump_current_sel_o(pump_current_sel_o));
